// file: rtl/mctc_top.sv
// Top of the three-channel 16-bit timer with AXI4-Lite registers.
// Assumes capture inputs are asynchronous pins; all logic on clk_sys.
// Operation
// RULE_01: Clear in counter write final state wins; written value discarded.
// RULE_02: Word write in final state wins over increment.
// RULE_03: Byte write in last two states skips increment; other byte kept.
// RULE_04: Register write in final state suppresses compare match event.
// RULE_05: Wrap during counter write keeps written value, wrap flag still set.
// RULE_06: Capture during register read final state returns pre-capture value.
// RULE_07: Capture clear beats increment; pre-clear count captured.
// RULE_08: Capture during register write final state wins; write dropped.
// RULE_09: Compare clear happens leaving match value; period N+1 ticks.
// RULE_10: Byte write to synced counter sets all synced counters fully.
// RULE_11: PWM mode disables capture; simultaneous A and B match suppressed.
// RULE_12: Function bit selects compare (0) or capture (1) outside PWM.
// RULE_13: Clear select 01 A, 10 B, 11 synchronous with sync bit.
// RULE_14: Three requests per channel; channel priority resettable and reorderable.
// RULE_15: Wrap flag set on up wrap FFFF-0 or down wrap 0-FFFF.
// RULE_16: Flag clears on read while set, then zero write.
// RULE_17: PWM pin high on match A, low on match B.
// RULE_18: Bus marks final access state and the state before it.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mctc_top #(
  parameter int NCH = mctc_pkg::NCH // Channel count
) (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [2:0] tick_src, // Prescaled tick pulses
  input wire logic [NCH-1:0] cap_a_pin, // Capture A pins
  input wire logic [NCH-1:0] cap_b_pin, // Capture B pins
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  output logic [NCH-1:0] pin_a_output, // PWM A outputs
  output logic irq // Interrupt level
);
  typedef enum logic [1:0] {W_IDLE, W_T2, W_T3, W_RESP} mctc_wst_t;
  typedef enum logic [1:0] {R_IDLE, R_T3, R_RESP} mctc_rst_t;
  mctc_wst_t wst_ff;
  mctc_rst_t rst_ff;
  logic aw_got_ff, w_got_ff;
  logic [11:0] awaddr_ff, araddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [15:0] ctrl_ff [NCH];
  logic [NCH-1:0] sync_ff, mask_a_ff, mask_b_ff, mask_w_ff;
  logic [NCH-1:0] st_a_ff, st_b_ff, st_w_ff, rd_a_ff, rd_b_ff, rd_w_ff;
  logic [5:0] prio_ff;
  logic [NCH-1:0] ca_s1_ff, ca_s2_ff, cb_s1_ff, cb_s2_ff;
  logic [15:0] cnt [NCH];
  logic [15:0] general_reg_a [NCH];
  logic [15:0] general_reg_b [NCH];
  logic [NCH-1:0] clr_e, ev_a, ev_b, ev_w, pin_a;
  logic [NCH-1:0] cnt_t3, cnt_t2, gra_t3, grb_t3;
  logic [NCH-1:0] ev_a_ff, ev_b_ff;
  logic sync_clr;
  logic [1:0] wch, rch;
  logic [4:0] wofs, rofs;
  logic wglob, rglob, wbyte, wmap, rmap;
  logic [15:0] wmerge;
  logic [31:0] nxt_rdata;
  logic [7:0] irq_vec_ff;
  assign wch = awaddr_ff[6:5];
  assign wofs = awaddr_ff[4:0];
  assign wglob = awaddr_ff[7];
  assign rch = araddr_ff[6:5];
  assign rofs = araddr_ff[4:0];
  assign rglob = araddr_ff[7];
  assign wbyte = (wstrb_ff[1:0] != 2'h3);
  assign wmap = (awaddr_ff[11:8] == 4'h0) & (wglob ? (awaddr_ff[6:0] <= 7'h10) : (32'(wch) < NCH));
  assign rmap = (araddr_ff[11:8] == 4'h0) & (rglob ? (araddr_ff[6:0] <= 7'h10) : (32'(rch) < NCH));
  // AXI write path: both channels taken in any order, then T2, T3, response
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wst_ff <= W_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      s_axi_awready <= (wst_ff == W_IDLE) & ~aw_got_ff & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= (wst_ff == W_IDLE) & ~w_got_ff & ~(s_axi_wvalid & s_axi_wready);
      case (wst_ff)
        W_IDLE: begin
          if (s_axi_awvalid & s_axi_awready) begin
            awaddr_ff <= s_axi_awaddr;
            aw_got_ff <= 1'b1;
          end
          if (s_axi_wvalid & s_axi_wready) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
            w_got_ff <= 1'b1;
          end
          if (aw_got_ff & w_got_ff) begin
            wst_ff <= W_T2; // [RULE_18]
          end
        end
        W_T2: wst_ff <= W_T3;
        W_T3: begin
          wst_ff <= W_RESP;
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= wmap ? 2'h0 : 2'h2;
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            wst_ff <= W_IDLE;
          end
        end
        default: wst_ff <= W_IDLE;
      endcase
    end
  end
  // Merge byte lanes into the addressed counter
  always_comb begin
    wmerge = cnt[(32'(wch) < NCH) ? wch : 2'h0];
    if (wstrb_ff[0]) begin
      wmerge[7:0] = wdata_ff[7:0];
    end
    if (wstrb_ff[1]) begin
      wmerge[15:8] = wdata_ff[15:8];
    end
  end
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cnt_t3[i] = (wst_ff == W_T3) & ~wglob & wmap & (wofs == mctc_pkg::OFS_CNT) & (wstrb_ff[1:0] != 2'h0) &
                  ((32'(wch) == i) | (sync_ff[i] & sync_ff[wch])); // [RULE_10]
      cnt_t2[i] = (wst_ff == W_T2) & ~wglob & wmap & (wofs == mctc_pkg::OFS_CNT) & wbyte &
                  ((32'(wch) == i) | (sync_ff[i] & sync_ff[wch])); // [RULE_03]
      gra_t3[i] = (wst_ff == W_T3) & ~wglob & wmap & (32'(wch) == i) & (wofs == mctc_pkg::OFS_GRA);
      grb_t3[i] = (wst_ff == W_T3) & ~wglob & wmap & (32'(wch) == i) & (wofs == mctc_pkg::OFS_GRB);
    end
  end
  // Configuration registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_ff[i] <= mctc_pkg::RST_CTRL;
      end
      sync_ff <= '0;
      mask_a_ff <= '0;
      mask_b_ff <= '0;
      mask_w_ff <= '0;
      prio_ff <= mctc_pkg::RST_PRIO; // [RULE_14]
    end else if (ce & (wst_ff == W_T3) & wmap) begin
      if (~wglob & (wofs == mctc_pkg::OFS_CTRL)) begin
        ctrl_ff[wch] <= wdata_ff[15:0];
      end
      if (wglob & (awaddr_ff[6:0] == mctc_pkg::OFS_SYNC[6:0])) begin
        sync_ff <= wdata_ff[NCH-1:0];
      end
      if (wglob & (awaddr_ff[6:0] == mctc_pkg::OFS_MASK[6:0])) begin
        mask_a_ff <= wdata_ff[NCH-1:0];
        mask_b_ff <= wdata_ff[8+NCH-1:8];
        mask_w_ff <= wdata_ff[16+NCH-1:16];
      end
      if (wglob & (awaddr_ff[6:0] == mctc_pkg::OFS_PRIO[6:0])) begin
        prio_ff <= wdata_ff[5:0]; // [RULE_14]
      end
    end
  end
  // Capture pin synchronisers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ca_s1_ff <= '0;
      ca_s2_ff <= '0;
      cb_s1_ff <= '0;
      cb_s2_ff <= '0;
    end else if (ce) begin
      ca_s1_ff <= cap_a_pin;
      ca_s2_ff <= ca_s1_ff;
      cb_s1_ff <= cap_b_pin;
      cb_s2_ff <= cb_s1_ff;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ev_a_ff <= '0;
      ev_b_ff <= '0;
    end else if (ce) begin
      ev_a_ff <= ca_s2_ff;
      ev_b_ff <= cb_s2_ff;
    end
  end
  assign sync_clr = |(clr_e & sync_ff);
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    mctc_channel u_ch (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .ctrl(ctrl_ff[g]),
      .tick(tick_src[ctrl_ff[g][mctc_pkg::B_TICK_LO +: 2]]),
      .sync_clr_in(sync_clr & sync_ff[g]), // [RULE_13]
      .cap_a_in(ca_s2_ff[g] & ~ev_a_ff[g]),
      .cap_b_in(cb_s2_ff[g] & ~ev_b_ff[g]),
      .cnt_wr_t3(cnt_t3[g]),
      .cnt_wr_t2(cnt_t2[g]),
      .cnt_wdata(wmerge),
      .gra_wr_t3(gra_t3[g]),
      .grb_wr_t3(grb_t3[g]),
      .gr_wdata(wdata_ff[15:0]),
      .cnt_q(cnt[g]),
      .gra_q(general_reg_a[g]),
      .grb_q(general_reg_b[g]),
      .clr_evt(clr_e[g]),
      .ev_a(ev_a[g]),
      .ev_b(ev_b[g]),
      .ev_wrap(ev_w[g]),
      .pin_a_output(pin_a[g])
    );
  end
  // Read data sampled in T3 from the registers before this edge
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (~rmap) begin
      nxt_rdata = 32'h00000000;
    end else if (~rglob) begin
      case (rofs)
        mctc_pkg::OFS_CNT: nxt_rdata = {16'h0000, cnt[rch]};
        mctc_pkg::OFS_GRA: nxt_rdata = {16'h0000, general_reg_a[rch]}; // [RULE_06]
        mctc_pkg::OFS_GRB: nxt_rdata = {16'h0000, general_reg_b[rch]}; // [RULE_06]
        mctc_pkg::OFS_CTRL: nxt_rdata = {16'h0000, ctrl_ff[rch]};
        default: nxt_rdata = 32'h00000000;
      endcase
    end else begin
      case (araddr_ff[6:0])
        mctc_pkg::OFS_SYNC[6:0]: nxt_rdata = 32'(sync_ff);
        mctc_pkg::OFS_STAT[6:0]: nxt_rdata = {8'h00, 5'h00, st_w_ff, 5'h00, st_b_ff, 5'h00, st_a_ff};
        mctc_pkg::OFS_MASK[6:0]: nxt_rdata = {8'h00, 5'h00, mask_w_ff, 5'h00, mask_b_ff, 5'h00, mask_a_ff};
        mctc_pkg::OFS_PRIO[6:0]: nxt_rdata = {26'h0000000, prio_ff};
        mctc_pkg::OFS_IRQV[6:0]: nxt_rdata = {24'h000000, irq_vec_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_ff <= R_IDLE;
      araddr_ff <= 12'h000;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= (rst_ff == R_IDLE) & ~(s_axi_arvalid & s_axi_arready);
      case (rst_ff)
        R_IDLE: begin
          if (s_axi_arvalid & s_axi_arready) begin
            araddr_ff <= s_axi_araddr;
            rst_ff <= R_T3;
          end
        end
        R_T3: begin
          s_axi_rdata <= nxt_rdata;
          s_axi_rresp <= rmap ? 2'h0 : 2'h2;
          s_axi_rvalid <= 1'b1;
          rst_ff <= R_RESP;
        end
        R_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rst_ff <= R_IDLE;
          end
        end
        default: rst_ff <= R_IDLE;
      endcase
    end
  end
  // Sticky flags: arm on read while set, clear on zero write; set wins
  logic stat_rd, stat_wr;
  assign stat_rd = (rst_ff == R_T3) & rglob & (araddr_ff[6:0] == mctc_pkg::OFS_STAT[6:0]);
  assign stat_wr = (wst_ff == W_T3) & wglob & (awaddr_ff[6:0] == mctc_pkg::OFS_STAT[6:0]);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_a_ff <= '0;
      st_b_ff <= '0;
      st_w_ff <= '0;
      rd_a_ff <= '0;
      rd_b_ff <= '0;
      rd_w_ff <= '0;
    end else if (ce) begin
      // [RULE_16]
      st_a_ff <= ev_a | (st_a_ff & ~(stat_wr ? (rd_a_ff & ~wdata_ff[NCH-1:0]) : '0));
      st_b_ff <= ev_b | (st_b_ff & ~(stat_wr ? (rd_b_ff & ~wdata_ff[8+NCH-1:8]) : '0));
      st_w_ff <= ev_w | (st_w_ff & ~(stat_wr ? (rd_w_ff & ~wdata_ff[16+NCH-1:16]) : '0)); // [RULE_05]
      if (stat_rd) begin
        rd_a_ff <= st_a_ff;
        rd_b_ff <= st_b_ff;
        rd_w_ff <= st_w_ff;
      end else if (stat_wr) begin
        rd_a_ff <= '0;
        rd_b_ff <= '0;
        rd_w_ff <= '0;
      end
    end
  end
  // Highest-priority pending source: channel order from prio, A then B then wrap
  logic [NCH-1:0] pend_a, pend_b, pend_w;
  logic [7:0] nxt_vec;
  logic [1:0] pc;
  assign pend_a = st_a_ff & mask_a_ff;
  assign pend_b = st_b_ff & mask_b_ff;
  assign pend_w = st_w_ff & mask_w_ff;
  always_comb begin
    nxt_vec = 8'h00;
    pc = 2'h0;
    for (int k = NCH - 1; k >= 0; k--) begin
      pc = prio_ff[2*k +: 2];
      if (32'(pc) < NCH) begin
        if (pend_w[pc]) begin
          nxt_vec = {4'h8, 2'h2, pc};
        end
        if (pend_b[pc]) begin
          nxt_vec = {4'h8, 2'h1, pc};
        end
        if (pend_a[pc]) begin
          nxt_vec = {4'h8, 2'h0, pc}; // [RULE_14]
        end
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
      irq_vec_ff <= 8'h00;
      pin_a_output <= '0;
    end else if (ce) begin
      irq <= |{pend_a, pend_b, pend_w};
      irq_vec_ff <= nxt_vec;
      pin_a_output <= pin_a;
    end
  end
endmodule
`default_nettype wire

// file: rtl/mctc_pkg.sv
// Shared constants for the three-channel timer with conflict resolution.
// Assumes a single clk_sys domain and an AXI4-Lite register bus.
package mctc_pkg;
  localparam int NCH = 3;
  localparam int CW = 16;
  // Per-channel block stride and register offsets within a block
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [4:0] OFS_CNT = 5'h00;
  localparam logic [4:0] OFS_GRA = 5'h04;
  localparam logic [4:0] OFS_GRB = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0C;
  // Global registers
  localparam logic [11:0] OFS_SYNC = 12'h080;
  localparam logic [11:0] OFS_STAT = 12'h084;
  localparam logic [11:0] OFS_MASK = 12'h088;
  localparam logic [11:0] OFS_PRIO = 12'h08C;
  localparam logic [11:0] OFS_IRQV = 12'h090;
  // Control field positions
  localparam int B_RUN = 0;
  localparam int B_DOWN = 1;
  localparam int B_PWM = 2;
  localparam int B_CAPA = 3;
  localparam int B_CAPB = 4;
  localparam int B_CLR_LO = 5;
  localparam int B_CLR_HI = 6;
  localparam int B_TICK_LO = 8;
  localparam int TICK_W = 8;
  // Reset values, counter limit and clear selects
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_GR = 16'hFFFF;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [5:0] RST_PRIO = 6'h24;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
endpackage

// file: rtl/mctc_channel.sv
// One 16-bit timer channel: counter, two general registers, one output pin.
// Assumes the top supplies access-phase strobes, all on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mctc_channel (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [15:0] ctrl, // Channel control
  input wire logic tick, // Increment pulse
  input wire logic sync_clr_in, // Clear from synced channels
  input wire logic cap_a_in, // Synced capture A edge
  input wire logic cap_b_in, // Synced capture B edge
  input wire logic cnt_wr_t3, // Counter write final state
  input wire logic cnt_wr_t2, // Counter write state before final
  input wire logic [15:0] cnt_wdata, // Merged counter write value
  input wire logic gra_wr_t3, // Reg A write final state
  input wire logic grb_wr_t3, // Reg B write final state
  input wire logic [15:0] gr_wdata, // General register write value
  output logic [15:0] cnt_q, // Counter value
  output logic [15:0] gra_q, // General reg A
  output logic [15:0] grb_q, // General reg B
  output logic clr_evt, // Own clear happened in the previous cycle
  output logic ev_a, // Match or capture A event
  output logic ev_b, // Match or capture B event
  output logic ev_wrap, // Wrap event
  output logic pin_a_output // Channel A output pin
);
  logic pwm, down, capa, capb, run;
  logic [1:0] clr_sel;
  logic inc, match_a, match_b, cma, cmb, cpa, cpb, wrap, clr_req;
  logic [15:0] nxt_cnt;
  assign pwm = ctrl[mctc_pkg::B_PWM];
  assign down = ctrl[mctc_pkg::B_DOWN];
  assign run = ctrl[mctc_pkg::B_RUN];
  assign capa = ctrl[mctc_pkg::B_CAPA] & ~pwm; // [RULE_11] [RULE_12]
  assign capb = ctrl[mctc_pkg::B_CAPB] & ~pwm; // [RULE_11] [RULE_12]
  assign clr_sel = {ctrl[mctc_pkg::B_CLR_HI], ctrl[mctc_pkg::B_CLR_LO]};
  assign inc = run & tick;
  // Match fires as the counter leaves the matching value
  assign match_a = inc & (cnt_q == gra_q) & ~capa;
  assign match_b = inc & (cnt_q == grb_q) & ~capb;
  assign cma = match_a & ~gra_wr_t3 & ~(pwm & match_b); // [RULE_04] [RULE_11]
  assign cmb = match_b & ~grb_wr_t3 & ~(pwm & match_a); // [RULE_04] [RULE_11]
  assign cpa = capa & cap_a_in;
  assign cpb = capb & cap_b_in;
  assign wrap = inc & (down ? (cnt_q == mctc_pkg::RST_CNT) : (cnt_q == mctc_pkg::CNT_MAX)); // [RULE_15]
  // [RULE_09] [RULE_13]
  assign clr_req = (clr_sel == mctc_pkg::CLR_A & (cma | cpa)) | (clr_sel == mctc_pkg::CLR_B & (cmb | cpb)) |
                   (clr_sel == mctc_pkg::CLR_SYNC & sync_clr_in);
  always_comb begin
    nxt_cnt = cnt_q;
    if (clr_req) begin
      nxt_cnt = mctc_pkg::RST_CNT; // [RULE_01] [RULE_07]
    end else if (cnt_wr_t3 | cnt_wr_t2) begin
      if (cnt_wr_t3) begin
        nxt_cnt = cnt_wdata; // [RULE_02] [RULE_03] [RULE_05]
      end
    end else if (inc) begin
      nxt_cnt = down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= mctc_pkg::RST_CNT;
    end else if (ce) begin
      cnt_q <= nxt_cnt;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gra_q <= mctc_pkg::RST_GR;
      grb_q <= mctc_pkg::RST_GR;
    end else if (ce) begin
      if (cpa) begin
        gra_q <= cnt_q; // [RULE_07] [RULE_08]
      end else if (gra_wr_t3) begin
        gra_q <= gr_wdata;
      end
      if (cpb) begin
        grb_q <= cnt_q; // [RULE_08]
      end else if (grb_wr_t3) begin
        grb_q <= gr_wdata;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clr_evt <= 1'b0;
      ev_a <= 1'b0;
      ev_b <= 1'b0;
      ev_wrap <= 1'b0;
      pin_a_output <= 1'b0;
    end else if (ce) begin
      clr_evt <= clr_req & (clr_sel != mctc_pkg::CLR_SYNC);
      ev_a <= cma | cpa;
      ev_b <= cmb | cpb;
      ev_wrap <= wrap; // [RULE_05]
      if (pwm & cma) begin
        pin_a_output <= 1'b1; // [RULE_17]
      end else if (pwm & cmb) begin
        pin_a_output <= 1'b0; // [RULE_17]
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/mctc_pin_model.sv
// Far-side pin model: tick pulses and capture levels for the timer.
// Assumes bench requests arrive on clk_sys and change after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module mctc_pin_model (
  input wire logic clk_sys, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic tick_req, // Request one tick
  input wire logic [2:0] lvl_a, // Wanted capture A levels
  input wire logic [2:0] lvl_b, // Wanted capture B levels
  output logic [2:0] tick_src, // Tick pulses
  output logic [2:0] cap_a_pin, // Capture A pins
  output logic [2:0] cap_b_pin // Capture B pins
);
  // One-cycle tick per request, levels follow one cycle later
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_src <= 3'h0;
      cap_a_pin <= 3'h0;
      cap_b_pin <= 3'h0;
    end else begin
      tick_src <= {3{tick_req}};
      cap_a_pin <= lvl_a;
      cap_b_pin <= lvl_b;
    end
  end
endmodule
`default_nettype wire

// file: verification/mctc_properties.sv
// Checker for mctc_top: bus answer timing, refusals and freeze.
// Assumes it is bound to mctc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mctc_properties #(
  parameter int NCH = 3 // Channel count
) (
  input wire logic clk_sys, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic [1:0] s_axi_bresp, // B response
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic [1:0] s_axi_rresp, // R response
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [NCH-1:0] pin_a_output, // Output pins
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> !s_axi_bvalid [*4] ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer off time");
  property p_rd_answer;
    s_rd_taken |-> !s_axi_rvalid [*2] ##1 s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer off time");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write ready while busy");
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read ready while busy");
  property p_ready_back;
    s_axi_bvalid && s_axi_bready |-> ##[1:2] s_axi_awready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("write ready not back");
  property p_slverr;
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000;
  endproperty
  a_slverr: assert property (p_slverr) else $error("refused read with data");
  property p_bresp;
    s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2;
  endproperty
  a_bresp: assert property (p_bresp) else $error("bad write response");
  property p_freeze;
    !ce |=> $stable(pin_a_output) && $stable(irq);
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved while frozen");
endmodule
bind mctc_top mctc_properties #(.NCH(NCH)) u_props (
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .pin_a_output(pin_a_output), .irq(irq)
);
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the three-channel timer over AXI4-Lite.
// Assumes mctc_top, the pin model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [4:0] CN = mctc_pkg::OFS_CNT, GA = mctc_pkg::OFS_GRA, GB = mctc_pkg::OFS_GRB;
  localparam logic [4:0] CT = mctc_pkg::OFS_CTRL;
  localparam logic [11:0] STAT = mctc_pkg::OFS_STAT, MASK = mctc_pkg::OFS_MASK;
  logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, treq = 1'b0;
  logic [2:0] cla = 3'h0, clb = 3'h0, tick_src, cap_a_pin, cap_b_pin, pin_a_output;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  int errors = 0, total_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  mctc_pin_model u_pins (.clk_sys(clk_sys), .rstn(rstn), .tick_req(treq), .lvl_a(cla), .lvl_b(clb),
    .tick_src(tick_src), .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin));
  mctc_top #(.NCH(3)) DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .tick_src(tick_src),
    .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_a_output(pin_a_output),
    .irq(irq));
  function automatic logic [11:0] ad(input int ch, input logic [4:0] o);
    return 12'(ch) * mctc_pkg::CH_STRIDE + {7'h00, o};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic rdt(input logic [11:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rdt(a);
    chk(rd, e);
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      treq <= 1'b1;
      @(posedge clk_sys);
      treq <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic ci(input logic e);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rc(ad(0, GA), 32'h0000FFFF);
    rc(mctc_pkg::OFS_PRIO, 32'h00000024);
    rdt(12'hFFC);
    chk({30'h0, rsp}, 32'h2);
    chk(rd, 32'h0);
    $display("test reset done");
    wr(MASK, 32'h00010101);
    wr(ad(0, CN), 32'hFFFF);
    wr(ad(0, CT), 32'h1);
    tk(1);
    rc(ad(0, CN), 32'h0);
    ci(1'b1);
    wr(MASK, 32'h0);
    ci(1'b0);
    ce <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ce <= 1'b1;
    wr(STAT, 32'h0);
    rc(STAT, 32'h00010101);
    wr(STAT, 32'h0);
    rc(STAT, 32'h0);
    wr(ad(0, CT), 32'h3);
    tk(1);
    rc(ad(0, CN), 32'h0000FFFF);
    rc(STAT, 32'h00010000);
    $display("test wrap and flags done");
    for (int i = 1; i < 3; i++) begin
      wr(ad(0, GA), (i == 1) ? 32'h3 : 32'h5);
      wr(ad(0, GB), (i == 1) ? 32'h5 : 32'h3);
      wr(ad(0, CN), 32'h0);
      wr(ad(0, CT), 32'(i << 5) | 32'h1);
      tk(3);
      rc(ad(0, CN), 32'h3);
      tk(1);
      rc(ad(0, CN), 32'h0);
    end
    $display("test compare clear done");
    wr(ad(0, CN), 32'h1234);
    wr(ad(0, CT), 32'h28);
    cla <= 3'h1;
    repeat (8) @(posedge clk_sys);
    rc(ad(0, GA), 32'h1234);
    rc(ad(0, CN), 32'h0);
    cla <= 3'h0;
    $display("test capture done");
    wr(ad(0, GA), 32'h2);
    wr(ad(0, GB), 32'h4);
    wr(ad(0, CN), 32'h0);
    wr(ad(0, CT), 32'h4D);
    cla <= 3'h1;
    tk(3);
    rc(ad(0, GA), 32'h2);
    chk({31'h0, pin_a_output[0]}, 32'h1);
    tk(2);
    chk({31'h0, pin_a_output[0]}, 32'h0);
    rc(ad(0, CN), 32'h0);
    $display("test pwm done");
    wr(ad(0, CT), 32'h0);
    wr(ad(0, CN), 32'h3400);
    wr(ad(1, CN), 32'h1200);
    wr(mctc_pkg::OFS_SYNC, 32'h3);
    wr(ad(0, CN), 32'h000000AB, 4'h1);
    rc(ad(0, CN), 32'h34AB);
    rc(ad(1, CN), 32'h34AB);
    $display("test sync write done");
    results();
  end
endmodule
`default_nettype wire
